// ---- hw/see_pkg.sv ----
// Shared constants, types and opcode decoding for the serial EEPROM front end
package see_pkg;

  // Core clock and internal programming time
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned T_WC_US      = 5000;
  localparam int unsigned WC_CYCLES    = (CLK_HZ / 1_000_000) * T_WC_US;
  localparam int unsigned BUSY_W       = 17;

  // Opcode decode: upper nibble zero, bit 3 ignored
  localparam logic [7:0] OPC_MASK      = 8'hf7;
  localparam logic [7:0] OPC_EN_SET    = 8'h06;
  localparam logic [7:0] OPC_EN_CLR    = 8'h04;
  localparam logic [7:0] OPC_STAT_RD   = 8'h05;
  localparam logic [7:0] OPC_STAT_WR   = 8'h01;
  localparam logic [7:0] OPC_READ      = 8'h03;
  localparam logic [7:0] OPC_WRITE     = 8'h02;

  // Status register layout
  localparam int unsigned ST_BUSY_B    = 0;
  localparam int unsigned ST_EN_B      = 1;
  localparam int unsigned ST_PROT0     = 2;
  localparam int unsigned ST_PROT1     = 3;
  localparam int unsigned ST_GPE       = 7;
  localparam logic [7:0] ST_RESET      = 8'h00;
  localparam logic [7:0] ST_WMASK      = 8'h8c;
  localparam logic [7:0] ST_BUSY_VIEW  = 8'hff;

  // Bit counter end value and synchroniser reset pattern
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [3:0] SYNC_RST      = 4'h3;

  typedef enum logic [1:0] {
    L_OPC  = 2'b00,
    L_BODY = 2'b01,
    L_STAT = 2'b10,
    L_DEAD = 2'b11
  } see_lst_e;

  // Frame state on the serial clock, cleared by deselect
  typedef struct packed {
    see_lst_e   st;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [7:0] tx;
    logic       body_seen;
  } see_link_s;

  // Events handed from the serial clock to the core clock
  typedef struct packed {
    logic       op_tgl;
    logic [7:0] op_word;
    logic       b1_tgl;
    logic [7:0] b1_word;
  } see_ev_s;

  // Output stage on the falling serial clock edge
  typedef struct packed {
    logic so;
    logic live;
  } see_out_s;

  // Core clock state
  typedef struct packed {
    logic              op_prev;
    logic              b1_prev;
    logic              wel;
    logic [7:0]        stat;
    logic              busy;
    logic [BUSY_W-1:0] cnt;
    logic              armed;
    logic              got;
    logic              abort;
    logic [7:0]        new_val;
    logic [7:0]        pub;
    logic              cmd_v;
    logic [7:0]        cmd_op;
    logic              rej;
  } see_core_s;

  function automatic logic see_opc_is(input logic [7:0] op, input logic [7:0] code);
    return (op & OPC_MASK) == code;
  endfunction

  function automatic logic see_opc_valid(input logic [7:0] op);
    return see_opc_is(op, OPC_EN_SET) | see_opc_is(op, OPC_EN_CLR) | see_opc_is(op, OPC_STAT_RD)
         | see_opc_is(op, OPC_STAT_WR) | see_opc_is(op, OPC_READ) | see_opc_is(op, OPC_WRITE);
  endfunction

endpackage

// ---- hw/see_sync.sv ----
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
module see_sync #(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Levels in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RST;
      q      <= RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ---- hw/see_front_end.sv ----
// Serial slave front end: selection, opcode intake, pause and status write guard
//
// Operation
// - Serial clock is only an input; the block is always a slave.
// - Bytes move most significant bit first in both directions.
// - First byte after select falls is the opcode for the whole selection.
// - Invalid opcode: take no more data, output off until next select.
// - Deselected: ignore serial input, output off.
// - Pause while selected suspends without losing the partial sequence.
// - Master releases pause while clock low; clock edges during pause are ignored.
// - Paused: output off, serial input ignored.
// - Guard pin high: reads and writes unrestricted.
// - Guard low with guard enable one rejects status register writes.
// - Guard low while selected aborts a status write not yet programming.
// - Guard has no effect once status programming has begun.
// - Guard enable zero: guard pin ignored entirely.
// - Opcode decode: upper nibble zero, bit 3 ignored, six valid codes.
// - Guard enable is status bit 7; protection needs it one and guard low.
`timescale 1ns/10ps
module see_front_end
  import see_pkg::*;
#(
  parameter int unsigned WC_CYC = WC_CYCLES
) (
  // Core clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Serial link pins
  input  wire logic       sclk,
  input  wire logic       device_select_n,
  input  wire logic       serial_in,
  input  wire logic       pause_n,
  input  wire logic       write_guard_n,
  output logic            serial_out_o,
  output logic            serial_out_oe,
  // User side
  output logic            cmd_valid,
  output logic [7:0]      cmd_opcode,
  output logic [7:0]      status_value,
  output logic            prog_busy,
  output logic            status_write_rejected
);

  see_link_s  lq;
  see_link_s  ln;
  see_ev_s    evq;
  see_ev_s    evn;
  see_out_s   oq;
  see_core_s  cq;
  see_core_s  cn;
  logic       frame_rst_n;
  logic [7:0] sh_next;
  logic       op_done;
  logic       b1_done;
  logic [3:0] sync_q;
  logic       op_tgl_s;
  logic       b1_tgl_s;
  logic       sel_n_s;
  logic       guard_n_s;
  logic       guard_on;
  logic [7:0] view;

  // Deselect clears the frame, so an invalid opcode lasts only until the next select
  assign frame_rst_n = resetn & ~device_select_n;

  // ---- Serial clock domain: the master owns the clock ----
  always_comb begin
    ln      = lq;
    op_done = 1'b0;
    b1_done = 1'b0;
    sh_next = {lq.sh[6:0], serial_in};
    if (pause_n) begin
      case (lq.st)
        L_OPC: begin
          ln.sh  = sh_next;
          ln.cnt = lq.cnt + 3'h1;
          if (lq.cnt == BIT_LAST) begin
            op_done = 1'b1;
            if (!see_opc_valid(sh_next)) begin
              ln.st = L_DEAD;
            end else if (see_opc_is(sh_next, OPC_STAT_RD)) begin
              ln.st = L_STAT;
              ln.tx = cq.pub;
            end else begin
              ln.st = L_BODY;
            end
          end
        end
        L_BODY: begin
          ln.sh  = sh_next;
          ln.cnt = lq.cnt + 3'h1;
          if (lq.cnt == BIT_LAST && !lq.body_seen) begin
            b1_done      = 1'b1;
            ln.body_seen = 1'b1;
          end
        end
        L_STAT: begin
          // Status repeats while the master keeps clocking
          ln.tx = {lq.tx[6:0], lq.tx[7]};
        end
        L_DEAD: begin
          ln = lq;
        end
        default: begin
          ln.st = L_DEAD;
        end
      endcase
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      lq <= '{st: L_OPC, sh: 8'h00, cnt: 3'h0, tx: 8'h00, body_seen: 1'b0};
    end else begin
      lq <= ln;
    end
  end

  // Event words stay put until the same stage of a later frame
  always_comb begin
    evn = evq;
    if (op_done) begin
      evn.op_tgl  = ~evq.op_tgl;
      evn.op_word = sh_next;
    end
    if (b1_done) begin
      evn.b1_tgl  = ~evq.b1_tgl;
      evn.b1_word = sh_next;
    end
  end

  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      evq <= '{op_tgl: 1'b0, op_word: 8'h00, b1_tgl: 1'b0, b1_word: 8'h00};
    end else begin
      evq <= evn;
    end
  end

  // Output changes on the falling edge
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      oq <= '{so: 1'b0, live: 1'b0};
    end else begin
      oq <= '{so: lq.tx[7], live: (lq.st == L_STAT)};
    end
  end

  assign serial_out_o  = oq.so;
  assign serial_out_oe = oq.live & pause_n & ~device_select_n;

  // ---- Core clock domain ----
  see_sync #(
    .W   (4),
    .RST (SYNC_RST)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({evq.op_tgl, evq.b1_tgl, device_select_n, write_guard_n}),
    .q      (sync_q)
  );

  assign op_tgl_s  = sync_q[3];
  assign b1_tgl_s  = sync_q[2];
  assign sel_n_s   = sync_q[1];
  assign guard_n_s = sync_q[0];

  // Protection only with guard enable set and guard pin low
  assign guard_on = cq.stat[ST_GPE] & ~guard_n_s;
  assign view     = cq.busy ? ST_BUSY_VIEW : ((cq.stat & ST_WMASK) | {6'h00, cq.wel, 1'b0});

  always_comb begin
    cn         = cq;
    cn.cmd_v   = 1'b0;
    cn.rej     = 1'b0;
    cn.op_prev = op_tgl_s;
    cn.b1_prev = b1_tgl_s;
    if (op_tgl_s != cq.op_prev) begin
      cn.cmd_v  = 1'b1;
      cn.cmd_op = evq.op_word;
      // Only status reads are served while programming
      if (!cq.busy) begin
        if (see_opc_is(evq.op_word, OPC_EN_SET)) begin
          cn.wel = 1'b1;
        end else if (see_opc_is(evq.op_word, OPC_EN_CLR)) begin
          cn.wel = 1'b0;
        end else if (see_opc_is(evq.op_word, OPC_STAT_WR)) begin
          cn.armed = 1'b1;
          cn.got   = 1'b0;
          cn.abort = 1'b0;
        end
      end
    end
    if (b1_tgl_s != cq.b1_prev && cn.armed) begin
      cn.got     = 1'b1;
      cn.new_val = evq.b1_word;
    end
    if (cn.armed && !sel_n_s && guard_on) begin
      cn.abort = 1'b1;
    end
    // Programming starts once the select rises
    if (cq.armed && sel_n_s) begin
      cn.armed = 1'b0;
      if (cn.got && cq.wel && !cn.abort && !guard_on) begin
        cn.busy = 1'b1;
        cn.cnt  = BUSY_W'(WC_CYC - 1);
      end else if (cn.got) begin
        cn.rej = 1'b1;
      end
    end
    // The guard is not consulted while programming runs
    if (cq.busy) begin
      if (cq.cnt == '0) begin
        cn.busy = 1'b0;
        cn.wel  = 1'b0;
        cn.stat = (cq.stat & ~ST_WMASK) | (cq.new_val & ST_WMASK);
      end else begin
        cn.cnt = cq.cnt - BUSY_W'(1);
      end
    end
    // Snapshot for the serial side moves only while deselected
    if (sel_n_s) begin
      cn.pub = view;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cq <= '{op_prev: 1'b0, b1_prev: 1'b0, wel: 1'b0, stat: ST_RESET, busy: 1'b0,
              cnt: '0, armed: 1'b0, got: 1'b0, abort: 1'b0, new_val: 8'h00,
              pub: ST_RESET, cmd_v: 1'b0, cmd_op: 8'h00, rej: 1'b0};
    end else begin
      cq <= cn;
    end
  end

  assign cmd_valid             = cq.cmd_v;
  assign cmd_opcode            = cq.cmd_op;
  assign status_value          = cq.pub;
  assign prog_busy             = cq.busy;
  assign status_write_rejected = cq.rej;

endmodule

// ---- testbench/see_front_end_properties.sv ----
// Concurrent checks on the serial front end ports
`timescale 1ns/10ps
module see_front_end_properties
  import see_pkg::*;
#(
  parameter int unsigned WC_CYC = 20
) (
  // Core clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Link pins
  input wire logic       sclk,
  input wire logic       device_select_n,
  input wire logic       serial_in,
  input wire logic       pause_n,
  input wire logic       write_guard_n,
  input wire logic       serial_out_o,
  input wire logic       serial_out_oe,
  // User side
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] status_value,
  input wire logic       prog_busy,
  input wire logic       status_write_rejected
);
  logic [BUSY_W-1:0] busy_cnt_q;

  // Length of the current programming run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      busy_cnt_q <= '0;
    else
      busy_cnt_q <= prog_busy ? busy_cnt_q + 1'b1 : '0;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_desel_quiet: assert property (device_select_n |-> !serial_out_oe)
    else $error("output driven while deselected");
  a_pause_quiet: assert property (!pause_n |-> !serial_out_oe)
    else $error("output driven while paused");
  a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
    else $error("opcode strobe longer than one cycle");
  a_opcode_hold: assert property ($changed(cmd_opcode) |-> cmd_valid)
    else $error("opcode changed without strobe");
  a_reject_single: assert property (status_write_rejected |=> !status_write_rejected)
    else $error("reject strobe longer than one cycle");
  a_reject_no_prog: assert property (status_write_rejected |=> !$rose(prog_busy))
    else $error("refused write started programming");
  a_busy_bound: assert property (busy_cnt_q <= WC_CYC + 1)
    else $error("programming ran too long");
  a_busy_length: assert property ($fell(prog_busy) |-> busy_cnt_q == WC_CYC)
    else $error("programming run had the wrong length");
  a_prog_after_desel: assert property ($rose(prog_busy) |-> $past(device_select_n))
    else $error("programming began while selected");
endmodule

// ---- testbench/see_spi_master_model.sv ----
// Behavioural SPI master that clocks frames only while selecting the device
`timescale 1ns/10ps
module see_spi_master_model (
  // Driven link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  output logic      pause_n,
  output logic      guard_n,
  // Sampled link pins
  input  wire logic so,
  input  wire logic oe
);
  logic [7:0] rx;
  logic       seen_oe;
  int         hold_bit = -1;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    pause_n = 1'b1;
    guard_n = 1'b1;
  end

  task automatic set_guard(input logic v);
    guard_n <= v;
  endtask

  task automatic xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      if (i == hold_bit) begin
        pause_n = 1'b0;
        repeat (3) begin
          mosi = ~mosi;
          #20 sclk = 1'b1;
          #20 sclk = 1'b0;
        end
        #20 pause_n = 1'b1;
        mosi = b[i];
      end
      #3 sclk = 1'b1;
      if (oe === 1'b1) begin
        rx = {rx[6:0], so};
        seen_oe = 1'b1;
      end
      #3 sclk = 1'b0;
    end
  endtask

  task automatic frame(input logic [15:0] d, input int nb);
    cs_n = 1'b0;
    rx = 8'h00;
    seen_oe = 1'b0;
    #120;
    for (int b = 0; b < nb; b++)
      xfer(d[15-8*b -: 8]);
    #3 cs_n = 1'b1;
    // Released line must not keep showing the last bit
    mosi = ~mosi;
    #200;
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the serial front end
`timescale 1ns/10ps
module testbench;
  import see_pkg::*;
  localparam int unsigned WC = 20;
  logic       clk, resetn, sclk, device_select_n, serial_in, pause_n, write_guard_n;
  logic       serial_out_o, serial_out_oe, cmd_valid, prog_busy, status_write_rejected;
  logic [7:0] cmd_opcode, status_value;
  int         miscompares, n_compared, n_cmd, n_rej, n_busy, c0;
  // Opcode in [8:1], expected output enable during the second byte in [0]
  logic [8:0] rows [15] = '{9'h040, 9'h1ec, 9'h10a, 9'h006, 9'h016, 9'h004, 9'h014,
                            9'h002, 9'h012, 9'h00b, 9'h01b, 9'h00c, 9'h01c, 9'h008, 9'h018};

  see_front_end #(.WC_CYC(WC)) dut_u (.clk(clk), .resetn(resetn), .sclk(sclk),
    .device_select_n(device_select_n), .serial_in(serial_in), .pause_n(pause_n),
    .write_guard_n(write_guard_n), .serial_out_o(serial_out_o),
    .serial_out_oe(serial_out_oe), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .status_value(status_value), .prog_busy(prog_busy),
    .status_write_rejected(status_write_rejected));
  see_spi_master_model mst_u (.sclk(sclk), .cs_n(device_select_n), .mosi(serial_in),
    .pause_n(pause_n), .guard_n(write_guard_n), .so(serial_out_o), .oe(serial_out_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (status_write_rejected === 1'b1) n_rej++;
    if (prog_busy === 1'b1) n_busy++;
  end

  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task summarize;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Enable, write the status byte, optionally drop the guard once programming runs
  task wr_status(input logic [7:0] v, input logic guard_late, input int exp_cyc);
    int k;
    int b0;
    b0 = n_busy;
    mst_u.frame({8'h06, 8'h00}, 1);
    mst_u.frame({8'h01, v}, 2);
    k = 0;
    while (prog_busy !== 1'b1 && k < 10) begin
      @(posedge clk);
      k++;
    end
    if (guard_late) mst_u.set_guard(1'b0);
    k = 0;
    while (prog_busy !== 1'b0 && k < WC + 10) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
    chk("busy cycles", 8'(n_busy - b0), 8'(exp_cyc));
  endtask

  initial begin
    #100_000;
    miscompares++;
    summarize();
  end

  initial begin
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("status after reset", status_value, 8'h00);
    foreach (rows[i]) begin
      c0 = n_cmd;
      mst_u.frame({rows[i][8:1], 8'h05}, 2);
      chk("opcode count", 8'(n_cmd - c0), 8'h01);
      chk("opcode", cmd_opcode, rows[i][8:1]);
      chk("output enable", {7'h00, mst_u.seen_oe}, {7'h00, rows[i][0]});
    end
    $display("opcode table done");
    wr_status(8'h8c, 1'b0, WC);
    chk("status written", status_value, 8'h8c);
    mst_u.hold_bit = 4;
    mst_u.frame({8'h05, 8'h00}, 2);
    mst_u.hold_bit = -1;
    chk("status read paused", mst_u.rx, 8'h8c);
    $display("write and paused read done");
    c0 = n_rej;
    mst_u.set_guard(1'b0);
    wr_status(8'h00, 1'b0, 0);
    chk("guarded status", status_value, 8'h8e);
    chk("reject count", 8'(n_rej - c0), 8'h01);
    mst_u.set_guard(1'b1);
    wr_status(8'h00, 1'b1, WC);
    chk("guard late", status_value, 8'h00);
    wr_status(8'h0c, 1'b0, WC);
    chk("guard disabled", status_value, 8'h0c);
    $display("guard tests done");
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    chk("status in reset", status_value, 8'h00);
    chk("busy in reset", {7'h00, prog_busy}, 8'h00);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    mst_u.frame({8'h05, 8'h00}, 2);
    chk("status read after reset", mst_u.rx, 8'h00);
    $display("mid-run reset done");
    summarize();
  end
endmodule

bind see_front_end see_front_end_properties #(.WC_CYC(WC_CYC)) chk_u (.clk(clk),
  .resetn(resetn), .sclk(sclk), .device_select_n(device_select_n),
  .serial_in(serial_in), .pause_n(pause_n), .write_guard_n(write_guard_n),
  .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe), .cmd_valid(cmd_valid),
  .cmd_opcode(cmd_opcode), .status_value(status_value), .prog_busy(prog_busy),
  .status_write_rejected(status_write_rejected));
